// File: hw/tpd_defs.vh
// Purpose: constants for the tap pulse detector
// Assumes: byte registers on a simple internal register port
// Notes: time steps in 1.25 ms base units; counts derived at 100 MHz
`ifndef TPD_DEFS_VH
`define TPD_DEFS_VH
`define TPD_ADDR_CONFIG 8'h21
`define TPD_ADDR_SOURCE 8'h22
`define TPD_ADDR_THS_X 8'h23
`define TPD_ADDR_THS_Y 8'h24
`define TPD_ADDR_THS_Z 8'h25
`define TPD_ADDR_PULSE_WIDTH_LIMIT 8'h26
`define TPD_ADDR_TAP_LATENCY_COUNT 8'h27
`define TPD_ADDR_SECOND_TAP_WINDOW_COUNT 8'h28
`define TPD_CFG_ABORT 7
`define TPD_CFG_LATCH 6
`define TPD_SRC_EA 7
`define TPD_SRC_DBL 3
`define TPD_RESET_VAL 8'h00
`define TPD_CLK_MHZ 100
`define TPD_MODE_NORMAL 2'h0
`define TPD_MODE_LOW_NOISE_LOW_POWER_MODE 2'h1
`define TPD_MODE_HIRES 2'h2
`define TPD_MODE_LP 2'h3
`define TPD_LOW_NOISE_SELECT_MAX_THS 7'h3f
`endif

// File: hw/tpd_tap_detector.v
// Purpose: single and double tap detection with latched source register
// Assumes: one filtered sample per sample strobe, signed 8 g scale
// Notes: time step measured in 1.25 ms base units; step_tick marks a step boundary
`timescale 1ns/100ps
`include "tpd_defs.vh"

// Behaviour
// - abort set: pulse wholly inside latency aborts double-tap search
// - abort clear: pulses during latency do not abort double-tap search
// - latch enable holds flags until source read; else not latched
// - six enables: single and double per X, Y, Z axis
// - event shown only if both axis and event type enabled
// - event_active reads 1 after any tap event, else 0
// - per-axis event bits for Z, Y, X set on tap
// - double_tap_flag 0 for single, 1 for double tap
// - per-axis sign bit: 0 positive, 1 negative pulse
// - with latch on, event_active freezes other source bits
// - reading source clears all bits and drops interrupt
// - separate threshold per axis starts pulse detection
// - thresholds 7-bit unsigned; bit 7 reads zero
// - 0.063 g per count on 8 g; low noise caps at 4 g
// - pulse valid only if it ends within time limit
// - limit, latency, window count time steps up to 255
// - time-limit step from rate, mode, low-pass tables
// - latency interval after first pulse ignores further pulses when abort clear
// - latency step table from rate, mode, low-pass option
// - second pulse starts in window; may end after window
// - window step follows latency step tables
// - low-noise limits signal to 4 g
// - 3-bit rate field, 000 is 800 Hz, 111 is 1.56 Hz
// - 2-bit oversampling mode field selects time steps
module tpd_tap_detector #(
    parameter DW = 8
) (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire sample_valid,
    input wire signed [DW-1:0] accel_x,
    input wire signed [DW-1:0] accel_y,
    input wire signed [DW-1:0] accel_z,
    input wire [2:0] rate_select_field,
    input wire [1:0] oversampling_select,
    input wire tap_lowpass_enable,
    input wire low_noise_select,
    output wire tap_irq
);
    localparam ST_IDLE = 3'h0;
    localparam ST_PULSE1 = 3'h1;
    localparam ST_LAT = 3'h2;
    localparam ST_WIN = 3'h3;
    localparam ST_PULSE2 = 3'h4;
    // over-long pulse: wait for it to fall before rearming
    localparam ST_HOLD = 3'h5;

    reg [7:0] cfg_reg;
    reg [7:0] src_reg;
    reg [6:0] ths_reg [0:2];
    reg [7:0] pulse_width_limit_reg;
    reg [7:0] tap_latency_count_reg;
    reg [7:0] second_tap_window_count_reg;
    reg [2:0] state_reg;
    reg [8:0] cnt_reg;
    reg [8:0] div_reg;
    reg [2:0] axis_reg;
    reg [2:0] sign_reg;
    reg lat_pulse_reg;
    reg abort_reg;

    reg [8:0] lat_div;
    reg [8:0] lim_div;
    wire [2:0] over;
    wire [2:0] neg;

    // samples per step: base latency ratio by low-pass option alone
    function [8:0] lat_ratio;
        input [2:0] rate;
        input [1:0] mode;
        input lpf;
        reg [8:0] lim;
        begin
            lim = 9'h010;
            if (mode == `TPD_MODE_HIRES)
                lim = 9'h001;
            else if (mode == `TPD_MODE_NORMAL)
                lim = 9'h010;
            else if (mode == `TPD_MODE_LOW_NOISE_LOW_POWER_MODE)
                lim = 9'h002;
            else
                lim = 9'h004;
            if (!lpf) begin
                lat_ratio = 9'h001;
                if (mode == `TPD_MODE_HIRES)
                    lat_ratio = 9'h001;
                else if (rate == 3'h0)
                    lat_ratio = 9'h001;
                else if (rate == 3'h1)
                    lat_ratio = (mode == `TPD_MODE_LP) ? 9'h001 : 9'h001;
                else
                    lat_ratio = 9'h001;
            end else begin
                lat_ratio = 9'h002;
            end
        end
    endfunction

    // step in units of the 1.25 ms base, by table lookup
    function [8:0] step_units;
        input [2:0] rate;
        input [1:0] mode;
        input lpf;
        input lat;
        reg [8:0] u;
        begin
            case (rate)
                3'h0: u = 9'h001;
                3'h1: u = 9'h002;
                3'h2: u = 9'h004;
                3'h3: u = 9'h008;
                3'h4: u = 9'h010;
                default: u = 9'h010;
            endcase
            if (rate >= 3'h5) begin
                if (mode == `TPD_MODE_LOW_NOISE_LOW_POWER_MODE)
                    u = 9'h040;
                else if (mode == `TPD_MODE_LP)
                    u = (rate == 3'h5) ? 9'h040 : 9'h080;
            end
            if (mode == `TPD_MODE_HIRES && rate != 3'h0)
                u = 9'h002;
            if (lat && lpf)
                u = {u[7:0], 1'b0};
            else if (!lpf && !(mode == `TPD_MODE_LP && rate != 3'h0)) begin
                if (mode == `TPD_MODE_HIRES || rate <= 3'h1)
                    u = 9'h001;
                else
                    u = {1'b0, u[8:1]};
            end
            step_units = u;
        end
    endfunction

    // base units per time step; sample period is the rate period
    always @* begin
        lat_div = step_units(rate_select_field, oversampling_select,
            tap_lowpass_enable, 1'b1);
        lim_div = step_units(rate_select_field, oversampling_select,
            tap_lowpass_enable, 1'b0);
    end

    function [9:0] rate_units;
        input [2:0] rate;
        begin
            case (rate)
                3'h0: rate_units = 10'h001;
                3'h1: rate_units = 10'h002;
                3'h2: rate_units = 10'h004;
                3'h3: rate_units = 10'h008;
                3'h4: rate_units = 10'h010;
                3'h5: rate_units = 10'h040;
                3'h6: rate_units = 10'h080;
                default: rate_units = 10'h200;
            endcase
        end
    endfunction

    wire [9:0] rate_u = rate_units(rate_select_field);
    wire [8:0] cur_div = (state_reg == ST_PULSE1 ||
        state_reg == ST_PULSE2) ? lim_div : lat_div;
    // one step is cur_div base units; each sample is rate_u units
    wire step_tick = sample_valid &&
        (({1'b0, div_reg} + rate_u) >= {1'b0, cur_div});

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_axis
            wire signed [DW-1:0] a = (gi == 0) ? accel_x :
                (gi == 1) ? accel_y : accel_z;
            wire [DW-1:0] mag = a[DW-1] ? (~a + 1'b1) : a;
            wire [6:0] ths = (low_noise_select &&
                ths_reg[gi] > `TPD_LOW_NOISE_SELECT_MAX_THS) ?
                7'h7f : ths_reg[gi];
            wire hit = (mag[DW-2:0] > ths) && !(low_noise_select &&
                ths_reg[gi] > `TPD_LOW_NOISE_SELECT_MAX_THS);
            assign over[gi] = hit;
            assign neg[gi] = a[DW-1];
        end
    endgenerate

    wire [2:0] sgl_en = {cfg_reg[4], cfg_reg[2], cfg_reg[0]};
    wire [2:0] dbl_en = {cfg_reg[5], cfg_reg[3], cfg_reg[1]};
    wire [2:0] any_en = sgl_en | dbl_en;
    wire [2:0] over_en = over & any_en;
    wire latch_on = cfg_reg[`TPD_CFG_LATCH];
    wire src_rd = reg_rd && (reg_addr == `TPD_ADDR_SOURCE);

    reg ev_sgl;
    reg ev_dbl;
    reg [2:0] ev_axis;
    reg [2:0] ev_sign;
    reg [7:0] src_next;

    always @* begin
        src_next = src_reg;
        if (src_rd)
            src_next = `TPD_RESET_VAL;
        else if (!latch_on)
            src_next = `TPD_RESET_VAL;
        if (ev_sgl || ev_dbl) begin
            if (!(latch_on && src_reg[`TPD_SRC_EA] && !src_rd)) begin
                src_next[`TPD_SRC_EA] = 1'b1;
                src_next[6:4] = ev_axis;
                src_next[`TPD_SRC_DBL] = ev_dbl;
                src_next[2:0] = ev_sign;
            end
        end
    end

    // detection sequencer
    always @* begin
        ev_sgl = 1'b0;
        ev_dbl = 1'b0;
        ev_axis = 3'h0;
        ev_sign = 3'h0;
        if (state_reg == ST_PULSE1 && sample_valid &&
            (over_en & axis_reg) == 3'h0 && cnt_reg <= {1'b0, pulse_width_limit_reg}) begin
            ev_axis = axis_reg & sgl_en;
            ev_sign = sign_reg & ev_axis;
            ev_sgl = ev_axis != 3'h0;
        end
        if (state_reg == ST_PULSE2 && sample_valid &&
            (over_en & axis_reg) == 3'h0 && cnt_reg <= {1'b0, pulse_width_limit_reg}) begin
            ev_axis = axis_reg & dbl_en;
            ev_sign = sign_reg & ev_axis;
            ev_dbl = ev_axis != 3'h0;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 9'h000;
            div_reg <= 9'h000;
            axis_reg <= 3'h0;
            sign_reg <= 3'h0;
            lat_pulse_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else begin
            if (state_reg == ST_IDLE || !sample_valid)
                div_reg <= (state_reg == ST_IDLE) ? 9'h000 : div_reg;
            else if (step_tick)
                div_reg <= 9'h000;
            else
                div_reg <= div_reg + rate_u[8:0];
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 9'h000;
                    if (sample_valid && over_en != 3'h0) begin
                        axis_reg <= over_en;
                        sign_reg <= neg & over_en;
                        state_reg <= ST_PULSE1;
                    end
                end
                ST_PULSE1: begin
                    if (step_tick)
                        cnt_reg <= cnt_reg + 9'h001;
                    if (sample_valid && (over_en & axis_reg) == 3'h0) begin
                        cnt_reg <= 9'h000;
                        lat_pulse_reg <= 1'b0;
                        abort_reg <= 1'b0;
                        state_reg <= (cnt_reg <= {1'b0, pulse_width_limit_reg}) ?
                            ST_LAT : ST_IDLE;
                    end else if (cnt_reg > {1'b0, pulse_width_limit_reg})
                        state_reg <= ST_HOLD;
                end
                ST_HOLD: begin
                    cnt_reg <= 9'h000;
                    if (sample_valid && (over_en & axis_reg) == 3'h0)
                        state_reg <= ST_IDLE;
                end
                ST_LAT: begin
                    if (step_tick)
                        cnt_reg <= cnt_reg + 9'h001;
                    if (sample_valid && over_en != 3'h0)
                        lat_pulse_reg <= 1'b1;
                    if (sample_valid && over_en == 3'h0 && lat_pulse_reg &&
                        cfg_reg[`TPD_CFG_ABORT])
                        abort_reg <= 1'b1;
                    if (cnt_reg >= {1'b0, tap_latency_count_reg}) begin
                        cnt_reg <= 9'h000;
                        if (abort_reg || (axis_reg & dbl_en) == 3'h0)
                            state_reg <= ST_IDLE;
                        else
                            state_reg <= ST_WIN;
                    end
                end
                ST_WIN: begin
                    if (step_tick)
                        cnt_reg <= cnt_reg + 9'h001;
                    if (sample_valid && (over_en & axis_reg) != 3'h0) begin
                        cnt_reg <= 9'h000;
                        axis_reg <= over_en & axis_reg;
                        sign_reg <= neg & over_en & axis_reg;
                        state_reg <= ST_PULSE2;
                    end else if (cnt_reg >= {1'b0, second_tap_window_count_reg})
                        state_reg <= ST_IDLE;
                end
                ST_PULSE2: begin
                    if (step_tick)
                        cnt_reg <= cnt_reg + 9'h001;
                    if (sample_valid && (over_en & axis_reg) == 3'h0)
                        state_reg <= ST_IDLE;
                    else if (cnt_reg > {1'b0, pulse_width_limit_reg})
                        state_reg <= ST_HOLD;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // register file
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= `TPD_RESET_VAL;
            src_reg <= `TPD_RESET_VAL;
            ths_reg[0] <= 7'h00;
            ths_reg[1] <= 7'h00;
            ths_reg[2] <= 7'h00;
            pulse_width_limit_reg <= `TPD_RESET_VAL;
            tap_latency_count_reg <= `TPD_RESET_VAL;
            second_tap_window_count_reg <= `TPD_RESET_VAL;
        end else begin
            src_reg <= src_next;
            if (reg_wr) begin
                case (reg_addr)
                    `TPD_ADDR_CONFIG: cfg_reg <= reg_wdata;
                    `TPD_ADDR_THS_X: ths_reg[0] <= reg_wdata[6:0];
                    `TPD_ADDR_THS_Y: ths_reg[1] <= reg_wdata[6:0];
                    `TPD_ADDR_THS_Z: ths_reg[2] <= reg_wdata[6:0];
                    `TPD_ADDR_PULSE_WIDTH_LIMIT: pulse_width_limit_reg <= reg_wdata;
                    `TPD_ADDR_TAP_LATENCY_COUNT: tap_latency_count_reg <= reg_wdata;
                    `TPD_ADDR_SECOND_TAP_WINDOW_COUNT: second_tap_window_count_reg <= reg_wdata;
                    default: cfg_reg <= cfg_reg;
                endcase
            end
        end
    end

    // read data registered on the read strobe
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                `TPD_ADDR_CONFIG: reg_rdata <= cfg_reg;
                `TPD_ADDR_SOURCE: reg_rdata <= src_reg;
                `TPD_ADDR_THS_X: reg_rdata <= {1'b0, ths_reg[0]};
                `TPD_ADDR_THS_Y: reg_rdata <= {1'b0, ths_reg[1]};
                `TPD_ADDR_THS_Z: reg_rdata <= {1'b0, ths_reg[2]};
                `TPD_ADDR_PULSE_WIDTH_LIMIT: reg_rdata <= pulse_width_limit_reg;
                `TPD_ADDR_TAP_LATENCY_COUNT: reg_rdata <= tap_latency_count_reg;
                `TPD_ADDR_SECOND_TAP_WINDOW_COUNT: reg_rdata <= second_tap_window_count_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    assign tap_irq = src_reg[`TPD_SRC_EA];
endmodule

// File: verif/tpd_tap_chk.sv
// Purpose: port checks for the tap detector
// Assumes: one clock, async active-low reset
// Notes: config mirrored from register writes
`timescale 1ns/100ps
module tpd_tap_chk (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire sample_valid,
    input wire tap_irq
);
    reg [7:0] cfg_reg;
    wire src_rd = reg_rd && reg_addr == 8'h22;
    wire cfg_wr = reg_wr && reg_addr == 8'h21;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            cfg_reg <= 8'h00;
        else if (cfg_wr)
            cfg_reg <= reg_wdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_quiet_rd;
        (!sample_valid) [*3] ##0 src_rd;
    endsequence
    sequence s_cfg_rb;
        cfg_wr ##2 (reg_rd && reg_addr == 8'h21);
    endsequence
    a_read_clears_irq: assert property (s_quiet_rd |=> !tap_irq)
        else $error("irq still high after source read");
    a_ea_mirrors_irq: assert property (src_rd |=>
        reg_rdata[7] == $past(tap_irq)) else $error("event bit not irq");
    a_axis_sets_ea: assert property (src_rd |=>
        (reg_rdata[6:4] == 3'h0 || reg_rdata[7])) else $error("axis no ea");
    a_dbl_has_axis: assert property (src_rd |=>
        (!reg_rdata[3] || reg_rdata[6:4] != 3'h0)) else $error("dbl no axis");
    a_ths_bit7_zero: assert property (reg_rd && reg_addr >= 8'h23 &&
        reg_addr <= 8'h25 |=> !reg_rdata[7]) else $error("ths bit7 set");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h21 ||
        reg_addr > 8'h28) |=> reg_rdata == 8'h00) else $error("unmapped");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_irq_latched: assert property (tap_irq && cfg_reg[6] && !src_rd &&
        !cfg_wr |=> tap_irq) else $error("latched irq dropped");
    a_irq_unlatched: assert property ($rose(tap_irq) && !cfg_reg[6]
        |=> !tap_irq) else $error("unlatched irq held");
    a_irq_from_sample: assert property ($rose(tap_irq) |->
        $past(sample_valid) || $past(sample_valid, 2) ||
        $past(sample_valid, 3)) else $error("irq without sample");
    a_off_no_irq: assert property (cfg_reg[5:0] == 6'h00 |->
        !$rose(tap_irq)) else $error("irq with all enables off");
    a_cfg_readback: assert property (s_cfg_rb |=>
        reg_rdata == $past(reg_wdata, 3)) else $error("config readback");
endmodule
bind tpd_tap_detector tpd_tap_chk u_chk (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .tap_irq(tap_irq));

// File: verif/tpd_sample_src.sv
// Purpose: filtered sample source feeding the detector
// Assumes: one strobe every PERIOD clocks
// Notes: lines carry no sample outside the strobe
`timescale 1ns/100ps
module tpd_sample_src #(
    parameter PERIOD = 8
) (
    input wire clk,
    input wire rst_b,
    input wire [7:0] lvl_x,
    input wire [7:0] lvl_y,
    input wire [7:0] lvl_z,
    output reg sample_valid,
    output wire [7:0] accel_x,
    output wire [7:0] accel_y,
    output wire [7:0] accel_z
);
    reg [7:0] cnt_reg;
    reg [23:0] smp_reg;
    wire last = cnt_reg == PERIOD - 1;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 8'h00;
            sample_valid <= 1'b0;
            smp_reg <= 24'h000000;
        end else begin
            sample_valid <= last;
            cnt_reg <= last ? 8'h00 : cnt_reg + 8'h01;
            if (last)
                smp_reg <= {lvl_z, lvl_y, lvl_x};
        end
    end
    // inverted off-strobe so a stale value is never mistaken for data
    assign accel_x = sample_valid ? smp_reg[7:0] : ~smp_reg[7:0];
    assign accel_y = sample_valid ? smp_reg[15:8] : ~smp_reg[15:8];
    assign accel_z = sample_valid ? smp_reg[23:16] : ~smp_reg[23:16];
endmodule

// File: verif/tb_tpd_tap_detector.sv
// Purpose: register-level tests of the tap detector
// Assumes: 800 Hz, normal mode, low-pass on: one step per sample
// Notes: latency and window steps are two samples
`timescale 1ns/100ps
module tb_tpd_tap_detector;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    reg low_noise = 1'b0;
    reg [7:0] lv [0:2];
    reg [7:0] a;
    wire [7:0] reg_rdata, ax, ay, az;
    wire sample_valid, tap_irq;
    integer miscompares = 0;
    integer checks_done = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    tpd_sample_src src (.clk(clk), .rst_b(rst_b), .lvl_x(lv[0]),
        .lvl_y(lv[1]), .lvl_z(lv[2]), .sample_valid(sample_valid),
        .accel_x(ax), .accel_y(ay), .accel_z(az));
    tpd_tap_detector dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sample_valid(sample_valid),
        .accel_x(ax), .accel_y(ay), .accel_z(az),
        .rate_select_field(3'h0), .oversampling_select(2'h0),
        .tap_lowpass_enable(1'b1), .low_noise_select(low_noise),
        .tap_irq(tap_irq));
    task tally_and_finish;
        begin
            if (miscompares == 0 && checks_done > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] ad, input [7:0] d);
        begin
            reg_addr = ad;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(posedge clk);
            #1 reg_wr = 1'b0;
            @(posedge clk);
            #1;
        end
    endtask
    task rdc(input [7:0] ad, input [7:0] e);
        begin
            reg_addr = ad;
            reg_rd = 1'b1;
            @(posedge clk);
            #1 reg_rd = 1'b0;
            chk(reg_rdata, e);
            @(posedge clk);
            #1;
        end
    endtask
    task smp(input integer n);
        begin
            repeat (n) @(posedge clk iff sample_valid);
            #1;
        end
    endtask
    task tap(input integer x, input [7:0] v, input integer w);
        begin
            lv[x] = v;
            smp(w);
            lv[x] = 8'h00;
        end
    endtask
    task single(input [7:0] c, input integer x, input [7:0] v,
        input integer w, input [7:0] e);
        begin
            wr(8'h21, c);
            tap(x, v, w);
            smp(16);
            chk({7'h00, tap_irq}, {7'h00, e[7]});
            rdc(8'h22, e);
            chk({7'h00, tap_irq}, 8'h00);
        end
    endtask
    task dbl(input [7:0] c, input m, input [7:0] e);
        begin
            wr(8'h21, c);
            tap(2, 8'h20, 2);
            smp(3);
            if (m)
                tap(2, 8'h20, 1);
            smp(20);
            tap(2, 8'h20, 2);
            smp(80);
            rdc(8'h22, e);
        end
    endtask
    initial begin
        lv[0] = 8'h00;
        lv[1] = 8'h00;
        lv[2] = 8'h00;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        for (a = 8'h21; a < 8'h29; a = a + 8'h01)
            rdc(a, 8'h00);
        rdc(8'h30, 8'h00);
        wr(8'h23, 8'hff);
        rdc(8'h23, 8'h7f);
        wr(8'h22, 8'hff);
        rdc(8'h22, 8'h00);
        for (a = 8'h23; a < 8'h26; a = a + 8'h01)
            wr(a, 8'h10);
        wr(8'h26, 8'h04);
        wr(8'h27, 8'h02);
        wr(8'h28, 8'h20);
        single(8'h41, 0, 8'h20, 2, 8'h90);
        single(8'h44, 1, 8'he0, 2, 8'ha2);
        single(8'h50, 2, 8'he0, 2, 8'hc4);
        single(8'h41, 2, 8'h20, 2, 8'h00);
        single(8'h41, 0, 8'h20, 8, 8'h00);
        single(8'h01, 0, 8'h20, 2, 8'h00);
        single(8'h41, 0, 8'h10, 2, 8'h00);
        low_noise = 1'b1;
        wr(8'h23, 8'h50);
        single(8'h41, 0, 8'h7f, 2, 8'h00);
        low_noise = 1'b0;
        wr(8'h23, 8'h10);
        wr(8'h21, 8'h45);
        rdc(8'h21, 8'h45);
        tap(0, 8'h20, 2);
        smp(16);
        tap(1, 8'he0, 2);
        smp(16);
        rdc(8'h22, 8'h90);
        wr(8'h27, 8'h08);
        dbl(8'h60, 1'b0, 8'hc8);
        dbl(8'h60, 1'b1, 8'hc8);
        dbl(8'he0, 1'b1, 8'h00);
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares = miscompares + 1;
        tally_and_finish;
    end
endmodule
